// ===== hw/fldc_dw_swap.sv
`timescale 1ns/1ps
// Byte reversal of one doubleword, applied per destination register
module fldc_dw_swap (
    input  wire logic        swap,
    input  wire logic [63:0] din,
    output logic      [63:0] dout
);
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_byte
            assign dout[8*b +: 8] = swap ? din[8*(7-b) +: 8] : din[8*b +: 8];
        end
    endgenerate
endmodule

// ===== hw/fldc_pkg.sv
package fldc_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [11:0] CTRL_OFS      = 12'h000;
    localparam logic [11:0] CMD_OFS       = 12'h004;
    localparam logic [11:0] STATUS_OFS    = 12'h008;
    localparam logic [11:0] INSN_OFS      = 12'h00C;
    localparam logic [11:0] RS1_OFS       = 12'h010;
    localparam logic [11:0] RS2_OFS       = 12'h014;
    localparam logic [11:0] ASI_REG_OFS   = 12'h018;
    localparam logic [11:0] IMPL_ASI_OFS  = 12'h01C;
    localparam logic [11:0] PAGE_OFS      = 12'h020;
    localparam logic [11:0] VA_WATCH_OFS  = 12'h024;
    localparam logic [11:0] PA_WATCH_OFS  = 12'h028;
    localparam logic [11:0] EADDR_OFS     = 12'h02C;
    localparam logic [5:0]  LINE_WIN      = 6'h01;  // haddr[11:6], 0x040
    localparam logic [3:0]  FPREG_WIN     = 4'h1;   // haddr[11:8], 0x100

    // CTRL fields
    localparam int CTRL_FEF_BIT   = 0;
    localparam int CTRL_PEF_BIT   = 1;
    localparam int CTRL_FPU_BIT   = 2;
    localparam int CTRL_PRIV_BIT  = 3;
    localparam int CTRL_HPRIV_BIT = 4;
    localparam int CTRL_VAW_BIT   = 5;
    localparam int CTRL_PAW_BIT   = 6;
    localparam logic [6:0] CTRL_RESET = 7'h07;

    // CMD fields
    localparam int CMD_GO_BIT    = 0;
    localparam int CMD_CLR_BIT   = 1;

    // PAGE fields
    localparam int PAGE_NC_BIT   = 0;
    localparam int PAGE_SE_BIT   = 1;
    localparam int PAGE_NFO_BIT  = 2;

    // Reset values
    localparam logic [7:0]  IMPL_ASI_RESET = 8'h80;
    localparam logic [31:0] WORD_RESET     = 32'h0000_0000;

    // Instruction encodings
    localparam logic [1:0] OP_LOAD_FMT   = 2'h3;
    localparam logic [5:0] OP3_SINGLE    = 6'h20;
    localparam logic [5:0] OP3_DOUBLE    = 6'h23;
    localparam logic [5:0] OP3_QUAD      = 6'h22;
    localparam logic [5:0] OP3_ALT_DBL   = 6'h33;

    // Block transfer identifiers
    localparam logic [7:0] ASI_BLK_AIUP  = 8'h16;
    localparam logic [7:0] ASI_BLK_AIUS  = 8'h17;
    localparam logic [7:0] ASI_BLK_AIUPL = 8'h1E;
    localparam logic [7:0] ASI_BLK_AIUSL = 8'h1F;
    localparam logic [7:0] ASI_BLK_P     = 8'hF0;
    localparam logic [7:0] ASI_BLK_S     = 8'hF1;
    localparam logic [7:0] ASI_BLK_PL    = 8'hF8;
    localparam logic [7:0] ASI_BLK_SL    = 8'hF9;
    localparam int ASI_LITTLE_BIT = 3;
    localparam int ASI_UNRESTRICTED_BIT = 7;

    // Block geometry
    localparam int BLOCK_ALIGN_BITS = 6;
    localparam logic [2:0] BLOCK_STEPS = 3'h7;  // eight doubles, minus one

    // Trap codes, in STATUS[7:4]
    typedef enum logic [3:0] {
        TRAP_NONE,
        TRAP_ILLEGAL,
        TRAP_FPU_OFF,
        TRAP_PRIV_ACTION,
        TRAP_MISALIGN,
        TRAP_DBL_MISALIGN,
        TRAP_NC_PAGE,
        TRAP_NFO_PAGE,
        TRAP_VA_WATCH,
        TRAP_PA_WATCH,
        TRAP_UNSUPPORTED
    } fldc_trap_t;

    typedef enum {
        ST_IDLE,
        ST_CHECK,
        ST_WRITE
    } fldc_state_t;

endpackage

// ===== hw/fldc_top.sv
//////////////////////////////////////////////////////////////////////////
// Behaviour
// RL1: block load destination must be eight-aligned
// RL2: FPU off or absent gives fpu-off trap
// RL3: block load needs 64-byte aligned address
// RL4: user mode, restricted block identifier: privileged trap
// RL5: block load to noncacheable page traps
// RL6: block load ignores page side-effect bit
// RL7: watchpoints cover all 64 block bytes
// RL8: block load recognised by its identifier
// RL9: single, double, quad opcode subfield decode
// RL10: address is rs1 plus rs2 or immediate
// RL11: register form needs bits 12:5 zero
// RL12: single load needs word alignment
// RL13: double on odd word: dedicated misalign trap
// RL14: quad misalign trap left to software
// RL15: quad bad register code left to software
// RL16: quad loads always illegal in hardware
// RL17: single writes word, double writes doubleword
// RL18: plain loads use implicit context identifier
// RL19: trapped load leaves destinations unchanged
// RL20: imprecise traps may leave destinations stale
// RL21: block fills eight doubles, lowest address first
// RL22: little identifiers swap bytes per register
// RL23: one trap by fixed priority, no write
//////////////////////////////////////////////////////////////////////////
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module fldc_top
    import fldc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    output logic             trap_valid,
    output logic      [3:0]  trap_code,
    output logic             load_done
);

    //////////////////////////////////////////////////////////////////////
    // Storage
    logic [6:0]  ctrl;
    logic [31:0] insn;
    logic [31:0] rs1_val;
    logic [31:0] rs2_val;
    logic [7:0]  asi_reg;
    logic [7:0]  impl_asi;
    logic [2:0]  page_attr;
    logic [31:0] va_watch;
    logic [31:0] pa_watch;
    logic [31:0] line_buf [0:15];  // 64-byte line served by memory
    logic [31:0] fp_reg   [0:63];  // single-precision view of the file
    fldc_state_t state;
    logic        done_flag;
    fldc_trap_t  last_trap;
    logic [7:0]  used_asi;
    logic        side_effect_access;
    logic [31:0] eaddr;
    logic [5:0]  dst_idx;
    logic [3:0]  word_idx;
    logic [2:0]  steps_left;
    logic        one_word;
    logic        swap_bytes;

    //////////////////////////////////////////////////////////////////////
    // AHB-Lite slave front end
    logic        wr_pend;
    logic        rd_pend;
    logic [11:0] dp_addr;
    logic        addr_take;
    logic        wr_en;
    logic        go_pulse;
    logic        clr_pulse;

    assign addr_take = hsel && hready && htrans[1];
    assign wr_en     = wr_pend;
    assign go_pulse  = wr_en && (dp_addr == CMD_OFS) && hwdata[CMD_GO_BIT];
    assign clr_pulse = wr_en && (dp_addr == CMD_OFS)
                     && hwdata[CMD_CLR_BIT];

    // One read wait state keeps writes visible; only OKAY is answered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            dp_addr   <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend <= addr_take && hwrite;
            rd_pend <= addr_take && !hwrite;
            if (addr_take) begin
                dp_addr <= haddr[11:0];
            end
            hreadyout <= !(addr_take && !hwrite);
        end
    end

    // Read mux, evaluated in the wait cycle
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = WORD_RESET;
        if (dp_addr[11:8] == FPREG_WIN) begin
            next_rdata = fp_reg[dp_addr[7:2]];
        end else if (dp_addr[11:6] == LINE_WIN) begin
            next_rdata = line_buf[dp_addr[5:2]];
        end else begin
            case (dp_addr)
                CTRL_OFS:     next_rdata = {25'h0000000, ctrl};
                STATUS_OFS:   next_rdata = {8'h00, used_asi, 7'h00,
                                            side_effect_access,
                                            last_trap, 2'h0, done_flag,
                                            state != ST_IDLE};
                INSN_OFS:     next_rdata = insn;
                RS1_OFS:      next_rdata = rs1_val;
                RS2_OFS:      next_rdata = rs2_val;
                ASI_REG_OFS:  next_rdata = {24'h000000, asi_reg};
                IMPL_ASI_OFS: next_rdata = {24'h000000, impl_asi};
                PAGE_OFS:     next_rdata = {29'h00000000, page_attr};
                VA_WATCH_OFS: next_rdata = va_watch;
                PA_WATCH_OFS: next_rdata = pa_watch;
                EADDR_OFS:    next_rdata = eaddr;
                default:      next_rdata = WORD_RESET;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= WORD_RESET;
        end else if (rd_pend) begin
            hrdata <= next_rdata;
        end
    end

    // Software-written configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl      <= CTRL_RESET;
            insn      <= WORD_RESET;
            rs1_val   <= WORD_RESET;
            rs2_val   <= WORD_RESET;
            asi_reg   <= 8'h00;
            impl_asi  <= IMPL_ASI_RESET;
            page_attr <= 3'h0;
            va_watch  <= WORD_RESET;
            pa_watch  <= WORD_RESET;
        end else if (wr_en) begin
            case (dp_addr)
                CTRL_OFS:     ctrl      <= hwdata[6:0];
                INSN_OFS:     insn      <= hwdata;
                RS1_OFS:      rs1_val   <= hwdata;
                RS2_OFS:      rs2_val   <= hwdata;
                ASI_REG_OFS:  asi_reg   <= hwdata[7:0];
                IMPL_ASI_OFS: impl_asi  <= hwdata[7:0];
                PAGE_OFS:     page_attr <= hwdata[2:0];
                VA_WATCH_OFS: va_watch  <= hwdata;
                PA_WATCH_OFS: pa_watch  <= hwdata;
                default:      ;
            endcase
        end
    end

    // No reset; memory contents start unknown
    always_ff @(posedge hclk) begin
        if (wr_en && dp_addr[11:6] == LINE_WIN) begin
            line_buf[dp_addr[5:2]] <= hwdata;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Decode and checks
    logic [1:0]  op_fmt;
    logic [5:0]  op3;
    logic [4:0]  rd;
    logic        imm_bit;
    logic [7:0]  asi_alt;
    logic        is_single;
    logic        is_double;
    logic        is_quad;
    logic        is_block;
    logic [31:0] offset;
    logic [31:0] ea;
    logic [31:0] ea_hi;
    logic        fpu_on;
    logic        nonpriv;
    logic        va_hit;
    logic        pa_hit;
    fldc_trap_t  next_trap;
    assign op_fmt  = insn[31:30];
    assign op3     = insn[24:19];
    assign rd      = insn[29:25];
    assign imm_bit = insn[13];
    assign asi_alt = imm_bit ? asi_reg : insn[12:5];
    always_comb begin
        is_single = (op_fmt == OP_LOAD_FMT) && (op3 == OP3_SINGLE);  // see RL9
        is_double = (op_fmt == OP_LOAD_FMT) && (op3 == OP3_DOUBLE);  // see RL9
        is_quad   = (op_fmt == OP_LOAD_FMT) && (op3 == OP3_QUAD);    // see RL9
        // Shared opcode; only the identifier tells a block load apart
        is_block  = 1'b0;
        if (op_fmt == OP_LOAD_FMT && op3 == OP3_ALT_DBL) begin
            case (asi_alt)
                ASI_BLK_AIUP, ASI_BLK_AIUS, ASI_BLK_AIUPL, ASI_BLK_AIUSL,
                ASI_BLK_P, ASI_BLK_S, ASI_BLK_PL, ASI_BLK_SL:
                    is_block = 1'b1;  // see RL8
                default: is_block = 1'b0;
            endcase
        end
    end

    // Effective address, sign-extended immediate or second register
    assign offset = imm_bit ? {{19{insn[12]}}, insn[12:0]} : rs2_val;
    assign ea     = rs1_val + offset;  // see RL10
    assign ea_hi  = is_block ? (ea | 32'h0000_003F)       // see RL7
                  : (is_single ? ea + 32'h0000_0003 : ea + 32'h0000_0007);
    assign fpu_on  = ctrl[CTRL_FEF_BIT] && ctrl[CTRL_PEF_BIT]
                   && ctrl[CTRL_FPU_BIT];
    assign nonpriv = !ctrl[CTRL_PRIV_BIT] && !ctrl[CTRL_HPRIV_BIT];

    // Translation is identity here, so both watches see the same range
    fldc_watch_match u_va_watch (.enable(ctrl[CTRL_VAW_BIT]),
        .watch_addr(va_watch), .lo_addr(ea), .hi_addr(ea_hi), .hit(va_hit));
    fldc_watch_match u_pa_watch (.enable(ctrl[CTRL_PAW_BIT]),
        .watch_addr(pa_watch), .lo_addr(ea), .hi_addr(ea_hi), .hit(pa_hit));

    // Fixed priority; the first match is the only trap reported
    always_comb begin
        next_trap = TRAP_NONE;
        if (!(is_single || is_double || is_quad || is_block)) begin
            next_trap = TRAP_UNSUPPORTED;
        end else if (!is_block && !imm_bit && insn[12:5] != 8'h00) begin
            next_trap = TRAP_ILLEGAL;                          // see RL11
        end else if (is_block && rd[2:0] != 3'h0) begin
            next_trap = TRAP_ILLEGAL;                          // see RL1
        end else if (!fpu_on) begin
            next_trap = TRAP_FPU_OFF;                          // see RL2
        end else if (is_quad) begin
            // Quad misalign and bad-register cases are software's job
            next_trap = TRAP_ILLEGAL;               // see RL16 RL14 RL15
        end else if (is_block && nonpriv
                     && !asi_alt[ASI_UNRESTRICTED_BIT]) begin
            next_trap = TRAP_PRIV_ACTION;                      // see RL4
        end else if (is_block
                     && ea[BLOCK_ALIGN_BITS-1:0] != 6'h00) begin
            next_trap = TRAP_MISALIGN;                         // see RL3
        end else if (ea[1:0] != 2'h0) begin
            next_trap = TRAP_MISALIGN;                         // see RL12
        end else if (is_double && ea[2]) begin
            next_trap = TRAP_DBL_MISALIGN;                     // see RL13
        end else if (is_block && page_attr[PAGE_NC_BIT]) begin
            next_trap = TRAP_NC_PAGE;                          // see RL5
        end else if (page_attr[PAGE_NFO_BIT]) begin
            next_trap = TRAP_NFO_PAGE;
        end else if (va_hit) begin
            next_trap = TRAP_VA_WATCH;                         // see RL7
        end else if (pa_hit) begin
            next_trap = TRAP_PA_WATCH;                         // see RL7
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Sequencer: check one cycle, then write one register or register pair a cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= ST_IDLE;
            last_trap  <= TRAP_NONE;
            used_asi   <= 8'h00;
            eaddr      <= WORD_RESET;
            dst_idx    <= 6'h00;
            word_idx   <= 4'h0;
            steps_left <= 3'h0;
            one_word   <= 1'b0;
            swap_bytes <= 1'b0;
            side_effect_access <= 1'b0;
        end else begin
            case (state)
                ST_IDLE:  state <= go_pulse ? ST_CHECK : ST_IDLE;
                ST_CHECK: begin
                    last_trap  <= next_trap;                   // see RL23
                    eaddr      <= ea;
                    used_asi   <= is_block ? asi_alt : impl_asi;  // see RL18
                    // Ordering hint is dropped for block accesses
                    side_effect_access <= page_attr[PAGE_SE_BIT]
                                          && !is_block;        // see RL6
                    word_idx   <= ea[5:2];
                    one_word   <= is_single;
                    swap_bytes <= is_block
                                  && asi_alt[ASI_LITTLE_BIT];  // see RL22
                    steps_left <= is_block ? BLOCK_STEPS : 3'h0;  // see RL21
                    dst_idx    <= is_single ? {1'b0, rd}
                                : {rd[0], rd[4:1], 1'b0};
                    // A trap ends here, so nothing reaches the file
                    state      <= (next_trap == TRAP_NONE) ? ST_WRITE
                                  : ST_IDLE;  // see RL19 RL20
                end
                ST_WRITE: begin
                    dst_idx  <= dst_idx + 6'h02;
                    word_idx <= word_idx + 4'h2;
                    steps_left <= steps_left - 3'h1;
                    if (steps_left == 3'h0) state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Register file write path
    logic [63:0] mem_dw;
    logic [63:0] fp_dw;
    // Lower address is the high half in big-endian order
    assign mem_dw = {line_buf[word_idx], line_buf[word_idx + 4'h1]};
    fldc_dw_swap u_swap (.swap(swap_bytes), .din(mem_dw), .dout(fp_dw));

    // Bus may preload the file; the sequencer wins on a clash
    always_ff @(posedge hclk) begin
        if (state == ST_WRITE) begin
            if (one_word) begin
                fp_reg[dst_idx] <= line_buf[word_idx];         // see RL17
            end else begin
                fp_reg[dst_idx]        <= fp_dw[63:32];        // see RL17
                fp_reg[dst_idx + 6'h1] <= fp_dw[31:0];         // see RL21
            end
        end else if (wr_en && dp_addr[11:8] == FPREG_WIN) begin
            fp_reg[dp_addr[7:2]] <= hwdata;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Completion flag and outputs toward the trap logic
    logic finish;
    assign finish = (state == ST_WRITE && steps_left == 3'h0)
                 || (state == ST_CHECK && next_trap != TRAP_NONE);

    // Set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_flag <= 1'b0;
        end else if (finish) begin
            done_flag <= 1'b1;
        end else if (clr_pulse) begin
            done_flag <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_valid <= 1'b0;
            trap_code  <= TRAP_NONE;
            load_done  <= 1'b0;
        end else begin
            trap_valid <= state == ST_CHECK && next_trap != TRAP_NONE;
            if (state == ST_CHECK) trap_code <= next_trap;  // see RL23
            load_done  <= finish;
        end
    end

endmodule

// ===== hw/fldc_watch_match.sv
`timescale 1ns/1ps
// Doubleword watchpoint against an inclusive byte range
module fldc_watch_match (
    input  wire logic        enable,
    input  wire logic [31:0] watch_addr,
    input  wire logic [31:0] lo_addr,
    input  wire logic [31:0] hi_addr,
    output logic             hit
);
    // Compare at doubleword granularity; byte masks are not modelled
    assign hit = enable
               && (watch_addr[31:3] >= lo_addr[31:3])
               && (watch_addr[31:3] <= hi_addr[31:3]);
endmodule

// ===== sim/fldc_master.sv
`timescale 1ns/1ps
// Host side bus master, single word transfers only
module fldc_master (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    // Quiet bus at time zero
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
    end

    // Address held until taken, then data held until ready
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'h1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        q = hrdata;
        hwdata <= ~d;  // Released lines must not keep old value
        haddr  <= ~a;
    endtask
endmodule

// ===== sim/fldc_props.sv
`timescale 1ns/1ps
module fldc_props
    import fldc_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        trap_valid,
    input wire logic [3:0]  trap_code,
    input wire logic        load_done
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic go_dp;

    // Marks the data phase of a command write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            go_dp <= 1'h0;
        end else if (hready) begin
            go_dp <= hsel & htrans[1] & hwrite & (haddr[11:0] == CMD_OFS);
        end
    end

    //////////////////////////////////////////////////////////////////
    property p_okay;
        hresp == 1'h0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rd_wait;
        hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_done_pulse;
        load_done |=> !load_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_trap_done;
        trap_valid |-> load_done;
    endproperty
    a_trap_done: assert property (p_trap_done)
        else $error("trap no done");
    property p_trap_code;
        trap_valid |-> trap_code inside {[1:10]};
    endproperty
    a_trap_code: assert property (p_trap_code)
        else $error("bad code");
    property p_clean;
        load_done && !trap_valid |-> trap_code == 4'h0;
    endproperty
    a_clean: assert property (p_clean)
        else $error("code on success");
    property p_go_done;
        go_dp && hready && hwdata[CMD_GO_BIT] |-> ##[1:12] load_done;
    endproperty
    a_go_done: assert property (p_go_done) else $error("load never ended");
    property p_code_hold;
        $changed(trap_code) |-> ##[0:9] load_done;
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("code moved");
endmodule

bind fldc_top fldc_props u_props (.*);

// ===== sim/fp_load_decode_check_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin \
    compares++; \
    if ((a) !== (e)) begin \
        errors++; \
        $display("FAIL %0t got %h exp %h", $time, (a), (e)); \
    end \
end
module fp_load_decode_check_bench
    import fldc_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        trap_valid, load_done;
    logic [31:0] haddr, hwdata, hrdata, q, s;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  trap_code;
    logic [31:0] lb [16];
    logic [31:0] fpm [64];
    int          errors, compares, cyc;

    // Clock, and a ceiling on run length
    initial begin
        hclk = 1'h0;
        hresetn = 1'h0;
    end
    always #2.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end

    fldc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .trap_valid(trap_valid),
        .trap_code(trap_code), .load_done(load_done));
    fldc_master m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    //////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        m.xfer(1'h1, {20'h0, a}, d, q);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        m.xfer(1'h0, {20'h0, a}, 32'h0, d);
    endtask
    function automatic logic [31:0] ins(logic [4:0] r, logic [5:0] o,
                                        logic i, logic [12:0] lo);
        return {2'h3, r, o, 5'h00, i, lo};
    endfunction
    function automatic logic [31:0] bsw(logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    // One load: wait for its end, then its trap code
    task automatic go(input logic [31:0] t, a1, a2, input logic [3:0] c);
        int n;
        wr(INSN_OFS, t);
        wr(RS1_OFS, a1);
        wr(RS2_OFS, a2);
        wr(CMD_OFS, 32'h1);
        n = 0;
        while (load_done !== 1'h1 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        `CHK(load_done, 1'h1)
        `CHK(trap_code, c)
        `CHK(trap_valid, c != 4'h0)
    endtask
    task automatic fchk(input int b, input int n);
        for (int k = b; k < b + n; k++) begin
            rd(12'h100 + 12'(4 * k), q);
            `CHK(q, fpm[k])
        end
    endtask

    //////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r1, r2, ea;
        logic [12:0] lo;
        logic [4:0]  rn;
        logic [3:0]  c;
        logic [7:0]  ba [8];
        ba = '{ASI_BLK_AIUP, ASI_BLK_AIUS, ASI_BLK_AIUPL, ASI_BLK_AIUSL,
               ASI_BLK_P, ASI_BLK_S, ASI_BLK_PL, ASI_BLK_SL};
        q = $urandom(84609);
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        rd(CTRL_OFS, q);
        `CHK(q, {25'h0, CTRL_RESET})
        rd(IMPL_ASI_OFS, q);
        `CHK(q, {24'h0, IMPL_ASI_RESET})
        wr(12'hFFC, 32'hFFFF_FFFF);
        rd(12'hFFC, q);
        `CHK(q, 32'h0)
        // Known line and FP contents; FP file has no reset
        for (int k = 0; k < 64; k++) begin
            lb[k % 16] = $urandom;
            wr(12'h040 + 12'(4 * (k % 16)), lb[k % 16]);
            fpm[k] = 32'h0;
            wr(12'h100 + 12'(4 * k), 32'h0);
        end
        // Every trap the checks can raise, except the NFO page and unsupported traps
        s = ins(5'h0, OP3_ALT_DBL, 1'h0, {ASI_BLK_P, 5'h0});
        go(ins(5'h0, OP3_SINGLE, 1'h0, 13'h20), 0, 0, TRAP_ILLEGAL);
        go(ins(5'h2, OP3_DOUBLE, 1'h1, 13'h4), 0, 0, TRAP_DBL_MISALIGN);
        go(ins(5'h2, OP3_QUAD, 1'h1, 13'h4), 0, 0, TRAP_ILLEGAL);
        go(s | 32'h0200_0000, 0, 0, TRAP_ILLEGAL);
        go(s, 8, 0, TRAP_MISALIGN);
        go(ins(5'h0, OP3_ALT_DBL, 1'h0, {ASI_BLK_AIUP, 5'h0}), 0, 0, 4'h3);
        wr(PAGE_OFS, 32'h1);
        go(s, 0, 0, TRAP_NC_PAGE);
        wr(PAGE_OFS, 32'h0);
        wr(VA_WATCH_OFS, 32'h38);
        wr(PA_WATCH_OFS, 32'h38);
        wr(CTRL_OFS, 32'h27);
        go(s, 0, 0, TRAP_VA_WATCH);
        wr(CTRL_OFS, 32'h47);
        go(s, 0, 0, TRAP_PA_WATCH);
        for (int k = 0; k < 3; k++) begin
            wr(CTRL_OFS, 32'h6 - 32'(k + k / 2));
            go(s, 8, 0, TRAP_FPU_OFF);
        end
        fchk(0, 16);
        // Every block identifier, side-effect page, privileged
        wr(CTRL_OFS, 32'h0F);
        wr(PAGE_OFS, 32'h2);
        for (int j = 0; j < 8; j++) begin
            rn = 5'(8 * (j % 4));
            for (int w = 0; w < 16; w++)
                fpm[rn + w] = ba[j][ASI_LITTLE_BIT] ? bsw(lb[w ^ 1]) : lb[w];
            s = ins(rn, OP3_ALT_DBL, 1'h0, {ba[j], 5'h0});
            go(s, 64 * j, 0, TRAP_NONE);
            rd(STATUS_OFS, q);
            `CHK(q[8], 1'h0)
            fchk(rn, 16);
        end
        wr(CTRL_OFS, 32'h07);
        fpm[34] = lb[2];
        fpm[35] = lb[3];
        go(ins(5'h3, OP3_DOUBLE, 1'h1, 13'h8), 0, 0, TRAP_NONE);
        fchk(34, 2);
        rd(STATUS_OFS, q);
        `CHK({q[23:16], q[8]}, {IMPL_ASI_RESET, 1'h1})
        wr(PAGE_OFS, 32'h0);
        // Random single loads in both address forms
        for (int k = 0; k < 24; k++) begin
            r1 = $urandom;
            r2 = $urandom & (k[1] ? 32'hFFFF_FFFC : 32'hFFFF_FFFF);
            lo = k[0] ? 13'($urandom) : 13'h0;
            rn = 5'($urandom);
            ea = k[0] ? r1 + {{19{lo[12]}}, lo} : r1 + r2;
            c = (ea[1:0] == 2'h0) ? TRAP_NONE : TRAP_MISALIGN;
            if (c == TRAP_NONE)
                fpm[rn] = lb[ea[5:2]];
            go(ins(rn, OP3_SINGLE, k[0], lo), r1, r2, c);
            fchk(rn, 1);
        end
        final_report();
    end
endmodule
